// ===== rtl/callerid_pkg.sv
`default_nettype none
package callerid_pkg;
  // --------------------------------------------------------------------------
  // timing
  // --------------------------------------------------------------------------
  localparam int clock_hz = 125000000;
  localparam real guard_tick_ms = 0.858;
  localparam int guard_tick_cycles = int'(guard_tick_ms * clock_hz / 1000.0);
  localparam real carrier_hyst_ms = 8.0;
  localparam int carrier_hyst_cycles = int'(carrier_hyst_ms * clock_hz / 1000.0);
  localparam int fsk_baud = 1200;
  localparam int fsk_bit_cycles = clock_hz / fsk_baud;
  localparam int fsk_byte_bits = 8;

  // --------------------------------------------------------------------------
  // internal register indices
  // --------------------------------------------------------------------------
  localparam logic [2:0] idx_row_tolerance_cfg = 3'h0;
  localparam logic [2:0] idx_col_tolerance_mode_cfg = 3'h1;
  localparam logic [2:0] idx_alert_fsk_gain_cfg = 3'h2;
  localparam logic [2:0] idx_digit_gain_cfg = 3'h3;
  localparam logic [2:0] idx_alert_digit_hyst_cfg = 3'h4;
  localparam logic [2:0] idx_fsk_hyst_filter_cfg = 3'h5;
  localparam int index_strobe_bit = 4;
  localparam int tone_mode_bit = 4;
  localparam int pt_restart_bit = 5;
  localparam int at_pause_bit = 6;
  localparam int tol_msb = 3;

  // --------------------------------------------------------------------------
  // reset values
  // --------------------------------------------------------------------------
  localparam logic [7:0] cfg_reset = 8'h00;
  localparam logic [7:0] guard_time_reset = 8'hff;

  // --------------------------------------------------------------------------
  // grouped signals
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic alert_raw_detect;
    logic digit_raw_detect;
    logic [3:0] digit_code;
    logic [3:0] freq_pair;
    logic high_band;
    logic low_band;
    logic fsk_band;
    logic demod_bit;
    logic demod_strobe;
  } front_end_type;

  typedef struct packed {
    logic [7:0] row_tolerance_cfg;
    logic [7:0] col_tolerance_mode_cfg;
    logic [7:0] alert_fsk_gain_cfg;
    logic [7:0] digit_gain_cfg;
    logic [7:0] alert_digit_hyst_cfg;
    logic [7:0] fsk_hyst_filter_cfg;
  } internal_cfg_type;

  typedef struct packed {
    logic [7:0] present_time;
    logic [7:0] absent_time;
    logic [7:0] count;
    logic qualified;
    logic counting;
    logic raw_d;
  } guard_type;
endpackage : callerid_pkg
`default_nettype wire

// ===== rtl/caller_id_detect_backend.sv
// Function
// - guard timer ticks every 0.858 ms for present and absent timing
// - raw alert rise clears timer; at present-time match, qualified alert rises
// - raw alert fall runs same timing against absent-time, then alert drops
// - qualified alert is hardware driven; its rise sets sticky alert flag
// - alert flag lives in flag register and raises common caller-ID flag
// - digit detection uses same guard procedure with own present/absent times
// - recognized digit raises digit-valid and stores code in bits 3:0
// - digit-valid rise sets sticky digit flag until software clears it
// - tone mode shows high/low group presence bits immediately
// - carrier detect rises after 8 ms present, falls after 8 ms absent
// - demodulated bits shown as serial bit with 1200 baud bit clock
// - each full byte goes to byte register and raises byte-ready
// - byte-ready rise sets sticky byte flag; software clears it
// - index bit 4 rising latches data into internal register at 3-bit index
// - indices 0..5 select the six internal configuration registers
// - row tolerance in bits 3:0 of register 0, upper bits zero
// - column tolerance in bits 3:0 of register 1
// - register 1 bit 5 set restarts present count on frequency change
// - register 1 bit 6 chooses absent count down or pause on reappearance
// - global enable gates fsk, alert and digit; each has own enable
`default_nettype none
module caller_id_detect_backend #(
  parameter int tick_cycles = callerid_pkg::guard_tick_cycles,
  parameter int carrier_cycles = callerid_pkg::carrier_hyst_cycles,
  parameter int bit_cycles = callerid_pkg::fsk_bit_cycles
) (
  input wire logic clock,
  input wire logic reset,
  input wire callerid_pkg::front_end_type front_end,
  input wire logic callerid_global_enable,
  input wire logic demod_enable,
  input wire logic alert_enable,
  input wire logic digit_receiver_enable,
  input wire logic [7:0] alert_present_time,
  input wire logic [7:0] alert_absent_time,
  input wire logic [7:0] digit_present_time,
  input wire logic [7:0] digit_absent_time,
  input wire logic [7:0] gain_write_data,
  input wire logic [7:0] gain_write_index,
  input wire logic [3:0] flag_clear,
  output logic [3:0] callerid_flag_reg,
  output logic callerid_common_flag,
  output logic alert_qualified,
  output logic digit_valid,
  output logic [7:0] digit_result,
  output logic carrier_detect,
  output logic demod_serial_bit,
  output logic demod_bit_clock,
  output logic byte_ready,
  output logic [7:0] fsk_rx_byte,
  output callerid_pkg::internal_cfg_type internal_cfg
);

  // --------------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic [31:0] tick_count;
    callerid_pkg::guard_type alert_g;
    callerid_pkg::guard_type digit_g;
    logic [3:0] freq_pair_d;
    logic digit_valid_d;
    logic [7:0] digit_result;
    logic [31:0] carrier_count;
    logic carrier_detect;
    logic [31:0] bit_count;
    logic demod_bit_clock;
    logic demod_serial_bit;
    logic [7:0] shift;
    logic [3:0] bit_index;
    logic [7:0] fsk_rx_byte;
    logic byte_ready;
    logic byte_ready_d;
    logic [3:0] flags;
    logic common_flag;
    logic strobe_d;
    callerid_pkg::internal_cfg_type cfg;
  } state_type;

  state_type state_reg;
  state_type state_next;
  logic tick;
  logic alert_on;
  logic fsk_on;
  logic digit_on;
  logic tone_mode;
  logic pair_changed;
  logic [3:0] flag_set;
  logic [2:0] write_index;

  // --------------------------------------------------------------------------
  // combinational update
  // --------------------------------------------------------------------------
  always_comb
  begin
    state_next = state_reg;
    alert_on = callerid_global_enable && alert_enable;
    fsk_on = callerid_global_enable && demod_enable;
    digit_on = callerid_global_enable && digit_receiver_enable;
    tone_mode = state_reg.cfg.col_tolerance_mode_cfg[callerid_pkg::tone_mode_bit];
    pair_changed = front_end.freq_pair != state_reg.freq_pair_d;
    flag_set = 4'h0;
    write_index = gain_write_index[2:0];

    // --------------------------------------------------------------------------
    // guard tick
    // --------------------------------------------------------------------------
    // one prescaler serves both timers, so the first tick after an edge lands 1 to tick_cycles cycles later
    tick = state_reg.tick_count >= 32'(tick_cycles - 1);
    state_next.tick_count = tick ? 32'h0 : state_reg.tick_count + 32'h1;

    // --------------------------------------------------------------------------
    // alert guard timer
    // --------------------------------------------------------------------------
    state_next.alert_g.present_time = alert_present_time;
    state_next.alert_g.absent_time = alert_absent_time;
    state_next.alert_g.raw_d = alert_on && front_end.alert_raw_detect;
    if (state_next.alert_g.raw_d != state_reg.alert_g.raw_d)
    begin
      state_next.alert_g.count = 8'h00;
      state_next.alert_g.counting = 1'b1;
    end
    else if (state_reg.alert_g.counting)
    begin
      if (state_reg.alert_g.count == (state_reg.alert_g.raw_d ? alert_present_time : alert_absent_time))
      begin
        state_next.alert_g.counting = 1'b0;
        state_next.alert_g.qualified = state_reg.alert_g.raw_d;
      end
      else if (tick)
        state_next.alert_g.count = state_reg.alert_g.count + 8'h01;
    end
    if (state_next.alert_g.qualified && !state_reg.alert_g.qualified)
      flag_set[1] = 1'b1;

    // --------------------------------------------------------------------------
    // digit guard timer
    // --------------------------------------------------------------------------
    state_next.freq_pair_d = front_end.freq_pair;
    state_next.digit_g.present_time = digit_present_time;
    state_next.digit_g.absent_time = digit_absent_time;
    state_next.digit_g.raw_d = digit_on && !tone_mode && front_end.digit_raw_detect;
    if (state_next.digit_g.raw_d && !state_reg.digit_g.raw_d && !state_reg.digit_g.qualified)
    begin
      state_next.digit_g.count = 8'h00;
      state_next.digit_g.counting = 1'b1;
    end
    // a fall during absent timing resumes the running count instead of restarting it
    else if (!state_next.digit_g.raw_d && state_reg.digit_g.raw_d && state_reg.digit_g.qualified
      && !state_reg.digit_g.counting)
    begin
      state_next.digit_g.count = 8'h00;
      state_next.digit_g.counting = 1'b1;
    end
    else if (state_reg.digit_g.counting)
    begin
      if (!state_reg.digit_g.qualified)
      begin
        if (!state_reg.digit_g.raw_d)
          state_next.digit_g.counting = 1'b0;
        else if (pair_changed && state_reg.cfg.col_tolerance_mode_cfg[callerid_pkg::pt_restart_bit])
          state_next.digit_g.count = 8'h00;
        else if (state_reg.digit_g.count == digit_present_time)
        begin
          state_next.digit_g.counting = 1'b0;
          state_next.digit_g.qualified = 1'b1;
          state_next.digit_result[3:0] = front_end.digit_code;
        end
        else if (tick)
          state_next.digit_g.count = state_reg.digit_g.count + 8'h01;
      end
      else
      begin
        if (state_reg.digit_g.raw_d)
        begin
          // digit reappeared during absent timing
          if (state_reg.cfg.col_tolerance_mode_cfg[callerid_pkg::at_pause_bit])
            state_next.digit_g.count = state_reg.digit_g.count;
          else if (tick && state_reg.digit_g.count != 8'h00)
            state_next.digit_g.count = state_reg.digit_g.count - 8'h01;
        end
        else if (state_reg.digit_g.count == digit_absent_time)
        begin
          state_next.digit_g.counting = 1'b0;
          state_next.digit_g.qualified = 1'b0;
        end
        else if (tick)
          state_next.digit_g.count = state_reg.digit_g.count + 8'h01;
      end
    end
    if (!digit_on)
    begin
      state_next.digit_g.qualified = 1'b0;
      state_next.digit_g.counting = 1'b0;
    end
    state_next.digit_valid_d = state_reg.digit_g.qualified;
    if (state_reg.digit_g.qualified && !state_reg.digit_valid_d)
      flag_set[2] = 1'b1;

    // --------------------------------------------------------------------------
    // tone detector presence bits
    // --------------------------------------------------------------------------
    state_next.digit_result[5] = digit_on && tone_mode && front_end.high_band;
    state_next.digit_result[4] = digit_on && tone_mode && front_end.low_band;
    state_next.digit_result[7:6] = 2'h0;

    // --------------------------------------------------------------------------
    // carrier detect hysteresis
    // --------------------------------------------------------------------------
    if ((fsk_on && front_end.fsk_band) == state_reg.carrier_detect)
      state_next.carrier_count = 32'h0;
    else if (state_reg.carrier_count >= 32'(carrier_cycles - 1))
    begin
      state_next.carrier_count = 32'h0;
      state_next.carrier_detect = !state_reg.carrier_detect;
    end
    else
      state_next.carrier_count = state_reg.carrier_count + 32'h1;

    // --------------------------------------------------------------------------
    // fsk bit clock and deserializer
    // --------------------------------------------------------------------------
    state_next.byte_ready = 1'b0;
    state_next.byte_ready_d = state_reg.byte_ready;
    if (!fsk_on)
    begin
      state_next.bit_count = 32'h0;
      state_next.demod_bit_clock = 1'b0;
      state_next.bit_index = 4'h0;
    end
    else if (front_end.demod_strobe)
    begin
      state_next.bit_count = 32'h0;
      state_next.demod_bit_clock = 1'b1;
      state_next.demod_serial_bit = front_end.demod_bit;
      state_next.shift = {front_end.demod_bit, state_reg.shift[7:1]};
      if (state_reg.bit_index == 4'(callerid_pkg::fsk_byte_bits - 1))
      begin
        state_next.bit_index = 4'h0;
        state_next.fsk_rx_byte = {front_end.demod_bit, state_reg.shift[7:1]};
        state_next.byte_ready = 1'b1;
      end
      else
        state_next.bit_index = state_reg.bit_index + 4'h1;
    end
    else if (state_reg.bit_count >= 32'(bit_cycles / 2 - 1))
      state_next.demod_bit_clock = 1'b0;
    else
      state_next.bit_count = state_reg.bit_count + 32'h1;
    if (state_reg.byte_ready && !state_reg.byte_ready_d)
      flag_set[3] = 1'b1;

    // --------------------------------------------------------------------------
    // sticky flags: set wins over clear
    // --------------------------------------------------------------------------
    state_next.flags = (state_reg.flags & ~flag_clear) | flag_set;
    state_next.common_flag = (state_reg.common_flag & ~flag_clear[0]) | (|flag_set);

    // --------------------------------------------------------------------------
    // indirect internal register write
    // --------------------------------------------------------------------------
    state_next.strobe_d = gain_write_index[callerid_pkg::index_strobe_bit];
    if (gain_write_index[callerid_pkg::index_strobe_bit] && !state_reg.strobe_d)
    begin
      case (write_index)
        callerid_pkg::idx_row_tolerance_cfg:
          state_next.cfg.row_tolerance_cfg = {4'h0, gain_write_data[callerid_pkg::tol_msb:0]};
        callerid_pkg::idx_col_tolerance_mode_cfg:
          state_next.cfg.col_tolerance_mode_cfg = gain_write_data;
        callerid_pkg::idx_alert_fsk_gain_cfg:
          state_next.cfg.alert_fsk_gain_cfg = gain_write_data;
        callerid_pkg::idx_digit_gain_cfg:
          state_next.cfg.digit_gain_cfg = gain_write_data;
        callerid_pkg::idx_alert_digit_hyst_cfg:
          state_next.cfg.alert_digit_hyst_cfg = gain_write_data;
        callerid_pkg::idx_fsk_hyst_filter_cfg:
          state_next.cfg.fsk_hyst_filter_cfg = gain_write_data;
        default:
          state_next.cfg = state_reg.cfg;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      state_reg <= '0;
      state_reg.alert_g.present_time <= callerid_pkg::guard_time_reset;
      state_reg.alert_g.absent_time <= callerid_pkg::guard_time_reset;
      state_reg.digit_g.present_time <= callerid_pkg::guard_time_reset;
      state_reg.digit_g.absent_time <= callerid_pkg::guard_time_reset;
      state_reg.cfg <= {6{callerid_pkg::cfg_reset}};
      // history starts high so a strobe bit already set at release does not write
      state_reg.strobe_d <= 1'b1;
    end
    else
      state_reg <= state_next;
  end

  // --------------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------------
  assign callerid_flag_reg = state_reg.flags;
  assign callerid_common_flag = state_reg.common_flag;
  assign alert_qualified = state_reg.alert_g.qualified;
  assign digit_valid = state_reg.digit_g.qualified;
  assign digit_result = state_reg.digit_result;
  assign carrier_detect = state_reg.carrier_detect;
  assign demod_serial_bit = state_reg.demod_serial_bit;
  assign demod_bit_clock = state_reg.demod_bit_clock;
  assign byte_ready = state_reg.byte_ready;
  assign fsk_rx_byte = state_reg.fsk_rx_byte;
  assign internal_cfg = state_reg.cfg;

endmodule : caller_id_detect_backend
`default_nettype wire

// ===== tb/caller_id_detect_backend_asserts.sv
`default_nettype none
module caller_id_detect_backend_asserts (
  input wire logic clock,
  input wire logic reset,
  input wire callerid_pkg::front_end_type front_end,
  input wire logic [7:0] gain_write_index,
  input wire logic [3:0] flag_clear,
  input wire logic [3:0] callerid_flag_reg,
  input wire logic callerid_common_flag,
  input wire logic alert_qualified,
  input wire logic digit_valid,
  input wire logic [7:0] digit_result,
  input wire logic byte_ready,
  input wire logic [7:0] fsk_rx_byte,
  input wire callerid_pkg::internal_cfg_type internal_cfg
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  sequence alert_rise;
    !alert_qualified ##1 alert_qualified;
  endsequence
  sequence digit_rise;
    !digit_valid ##1 digit_valid;
  endsequence
  a_alert_flag_set: assert property (alert_rise |-> ##[0:1] callerid_flag_reg[1])
    else $error("alert flag not set after qualified alert");
  a_digit_flag_set: assert property (digit_rise |-> ##[0:1] callerid_flag_reg[2])
    else $error("digit flag not set after digit valid");
  a_digit_code_load: assert property (digit_rise |-> digit_result[3:0] == $past(front_end.digit_code))
    else $error("digit code not loaded");
  a_byte_flag_set: assert property (byte_ready |-> ##1 callerid_flag_reg[3])
    else $error("byte flag not set after byte ready");
  a_common_flag_raise: assert property (($rose(callerid_flag_reg[1]) || $rose(callerid_flag_reg[2])
    || $rose(callerid_flag_reg[3])) |-> ##[0:1] callerid_common_flag)
    else $error("common flag not raised");
  a_alert_flag_sticky: assert property (callerid_flag_reg[1] && !flag_clear[1] |=> callerid_flag_reg[1])
    else $error("alert flag dropped without clear");
  a_byte_reg_hold: assert property ($changed(fsk_rx_byte) |-> byte_ready)
    else $error("byte register changed without byte ready");
  a_byte_ready_pulse: assert property (byte_ready |=> !byte_ready)
    else $error("byte ready longer than one cycle");
  a_cfg_write_edge: assert property ($changed(internal_cfg) |->
    $past(gain_write_index[4]) && !$past(gain_write_index[4], 2))
    else $error("internal register written without strobe rise");
endmodule : caller_id_detect_backend_asserts
`default_nettype wire

// ===== tb/front_end_model.sv
`default_nettype none
module front_end_model #(
  parameter int bit_cycles = 16
) (
  input wire logic clock,
  input wire logic alert_on,
  input wire logic digit_on,
  input wire logic [3:0] code,
  input wire logic [2:0] bands,
  input wire logic send,
  input wire logic [7:0] data,
  output callerid_pkg::front_end_type front_end,
  output logic busy
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] shift_reg = 8'h00;
  logic [3:0] bit_reg = 4'h0;
  int cnt_reg = 0;
  logic dbit_reg = 1'b0;
  logic strobe_reg = 1'b0;
  initial busy = 1'b0;
  // demodulated bits lsb first; data line toggles outside its strobe
  always @(posedge clock)
  begin
    strobe_reg <= 1'b0;
    dbit_reg <= ~dbit_reg;
    if (!busy && send)
    begin
      busy <= 1'b1;
      shift_reg <= data;
      bit_reg <= 4'h0;
      cnt_reg <= 0;
    end
    else if (busy && cnt_reg == bit_cycles - 1)
    begin
      cnt_reg <= 0;
      dbit_reg <= shift_reg[0];
      strobe_reg <= 1'b1;
      shift_reg <= shift_reg >> 1;
      bit_reg <= bit_reg + 4'h1;
      busy <= (bit_reg != 4'h7);
    end
    else if (busy)
      cnt_reg <= cnt_reg + 1;
  end
  assign front_end = {alert_on, digit_on, code, code, bands, dbit_reg, strobe_reg};
endmodule : front_end_model
`default_nettype wire

// ===== tb/test_caller_id_detect_backend.sv
`default_nettype none
module test_caller_id_detect_backend;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic callerid_global_enable = 1'b1, demod_enable = 1'b1, alert_enable = 1'b1, digit_receiver_enable = 1'b1;
  logic [7:0] alert_present_time = 8'h03, alert_absent_time = 8'h02;
  logic [7:0] digit_present_time = 8'h02, digit_absent_time = 8'h02;
  logic [7:0] gain_write_data = 8'h00, gain_write_index = 8'h00, data = 8'h00;
  logic [3:0] flag_clear = 4'h0, code = 4'h0;
  logic [2:0] bands = 3'h0;
  logic alert_on = 1'b0, digit_on = 1'b0, send = 1'b0, busy;
  callerid_pkg::front_end_type front_end;
  logic [3:0] callerid_flag_reg;
  logic callerid_common_flag, alert_qualified, digit_valid, carrier_detect, demod_serial_bit, demod_bit_clock;
  logic byte_ready;
  logic [7:0] digit_result, fsk_rx_byte;
  callerid_pkg::internal_cfg_type internal_cfg;
  int bad_count = 0, n_tests = 0;

  caller_id_detect_backend #(.tick_cycles(4), .carrier_cycles(20), .bit_cycles(16)) caller_id_detect_backend_i (
    .clock, .reset, .front_end, .callerid_global_enable, .demod_enable, .alert_enable, .digit_receiver_enable,
    .alert_present_time, .alert_absent_time, .digit_present_time, .digit_absent_time, .gain_write_data,
    .gain_write_index, .flag_clear, .callerid_flag_reg, .callerid_common_flag, .alert_qualified, .digit_valid,
    .digit_result, .carrier_detect, .demod_serial_bit, .demod_bit_clock, .byte_ready, .fsk_rx_byte, .internal_cfg);
  front_end_model #(.bit_cycles(16)) front_end_model_i (
    .clock, .alert_on, .digit_on, .code, .bands, .send, .data, .front_end, .busy);

  task stop_test;
    $display("mismatches %0d comparisons %0d", bad_count, n_tests);
    if (bad_count == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : stop_test

  task check(input logic [47:0] seen, input logic [47:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task cyc(input int n);
    repeat (n) @(negedge clock);
  endtask : cyc

  task automatic wait_level(ref logic s, input logic v, input int lim);
    for (int i = 0; i < lim && s !== v; i++) @(negedge clock);
  endtask : wait_level

  task pulse_clear(input logic [3:0] bits);
    @(posedge clock) flag_clear <= bits;
    @(posedge clock) flag_clear <= 4'h0;
    cyc(2);
  endtask : pulse_clear

  task write_cfg(input logic [2:0] idx, input logic [7:0] d);
    @(posedge clock) gain_write_data <= d;
    gain_write_index <= {5'h00, idx};
    @(posedge clock) gain_write_index <= {5'h02, idx};
    @(posedge clock) gain_write_index <= {5'h00, idx};
    cyc(2);
  endtask : write_cfg

  task t_cfg;
    for (int i = 0; i < 6; i++) write_cfg(i[2:0], 8'ha3 + i[7:0]);
    check(internal_cfg, {8'h03, 8'ha4, 8'ha5, 8'ha6, 8'ha7, 8'ha8});
    @(posedge clock) gain_write_data <= 8'h66;
    gain_write_index <= 8'h13;
    @(posedge clock) gain_write_data <= 8'h11;
    cyc(4);
    write_cfg(3'h6, 8'hee);
    check(internal_cfg, {8'h03, 8'ha4, 8'ha5, 8'h66, 8'ha7, 8'ha8});
  endtask : t_cfg

  task t_alert;
    @(posedge clock) alert_on <= 1'b1;
    cyc(8);
    check(alert_qualified, 1'b0);
    wait_level(alert_qualified, 1'b1, 20);
    check(alert_qualified, 1'b1);
    cyc(2);
    check({callerid_common_flag, callerid_flag_reg}, 5'h12);
    @(posedge clock) alert_on <= 1'b0;
    cyc(3);
    check(alert_qualified, 1'b1);
    wait_level(alert_qualified, 1'b0, 20);
    check({alert_qualified, callerid_flag_reg}, 5'h02);
    pulse_clear(4'h3);
    check({callerid_common_flag, callerid_flag_reg}, 5'h00);
    @(posedge clock) callerid_global_enable <= 1'b0;
    alert_on <= 1'b1;
    cyc(30);
    check(alert_qualified, 1'b0);
    @(posedge clock) alert_on <= 1'b0;
    callerid_global_enable <= 1'b1;
    cyc(10);
  endtask : t_alert

  task t_digit;
    @(posedge clock) code <= 4'h9;
    digit_on <= 1'b1;
    wait_level(digit_valid, 1'b1, 20);
    check({digit_valid, digit_result[3:0]}, 5'h19);
    cyc(2);
    check(callerid_flag_reg, 4'h4);
    @(posedge clock) digit_on <= 1'b0;
    wait_level(digit_valid, 1'b0, 20);
    pulse_clear(4'h5);
    write_cfg(3'h1, 8'h10);
    @(posedge clock) bands <= 3'b100;
    cyc(3);
    check(digit_result[5:4], 2'b10);
    @(posedge clock) bands <= 3'b010;
    cyc(3);
    check(digit_result[5:4], 2'b01);
    @(posedge clock) bands <= 3'b000;
    write_cfg(3'h1, 8'ha4);
  endtask : t_digit

  task t_restart(input logic [7:0] mode);
    write_cfg(3'h1, mode);
    @(posedge clock) digit_on <= 1'b1;
    repeat (10)
    begin
      @(posedge clock) code <= code + 4'h1;
      cyc(2);
    end
    check(digit_valid, !mode[5]);
    @(posedge clock) digit_on <= 1'b0;
    wait_level(digit_valid, 1'b0, 40);
    pulse_clear(4'h5);
  endtask : t_restart

  task t_absent(input logic [7:0] mode);
    write_cfg(3'h1, mode);
    @(posedge clock) digit_absent_time <= 8'h04;
    digit_on <= 1'b1;
    wait_level(digit_valid, 1'b1, 20);
    @(posedge clock) digit_on <= 1'b0;
    repeat (8) @(posedge clock);
    digit_on <= 1'b1;
    repeat (12) @(posedge clock);
    digit_on <= 1'b0;
    cyc(12);
    check(digit_valid, !mode[6]);
    wait_level(digit_valid, 1'b0, 30);
    pulse_clear(4'h5);
  endtask : t_absent

  task t_fsk;
    logic [7:0] bytes [2];
    bytes = '{8'ha5, 8'h3c};
    @(posedge clock) bands <= 3'b001;
    cyc(10);
    check(carrier_detect, 1'b0);
    wait_level(carrier_detect, 1'b1, 20);
    check(carrier_detect, 1'b1);
    foreach (bytes[i])
    begin
      @(posedge clock) data <= bytes[i];
      send <= 1'b1;
      @(posedge clock) send <= 1'b0;
      wait_level(byte_ready, 1'b1, 200);
      check({byte_ready, fsk_rx_byte, demod_serial_bit}, {1'b1, bytes[i], bytes[i][7]});
      cyc(2);
      check(callerid_flag_reg[3], 1'b1);
      check(demod_bit_clock, 1'b1);
      cyc(6);
      check(demod_bit_clock, 1'b0);
    end
    cyc(40);
    check(fsk_rx_byte, 8'h3c);
    @(posedge clock) bands <= 3'b000;
    cyc(10);
    check(carrier_detect, 1'b1);
    wait_level(carrier_detect, 1'b0, 20);
    check(carrier_detect, 1'b0);
    pulse_clear(4'h9);
  endtask : t_fsk

  initial
  begin
    forever #4 clock = ~clock;
  end

  initial
  begin
    repeat (8) @(posedge clock);
    reset <= 1'b0;
    t_cfg();
    t_alert();
    t_digit();
    t_restart(8'ha4);
    t_restart(8'h04);
    t_absent(8'h04);
    t_absent(8'h44);
    t_fsk();
    stop_test();
  end

  initial
  begin
    #50us;
    bad_count++;
    stop_test();
  end
endmodule : test_caller_id_detect_backend

bind caller_id_detect_backend caller_id_detect_backend_asserts checker_i (
  .clock, .reset, .front_end, .gain_write_index, .flag_clear, .callerid_flag_reg, .callerid_common_flag,
  .alert_qualified, .digit_valid, .digit_result, .byte_ready, .fsk_rx_byte, .internal_cfg);
`default_nettype wire
